// *** logic/mie_regs.svh ***
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH

`define MIE_DATA_W       8
`define MIE_PROG_W       16
`define MIE_PAGE_W       8
`define MIE_LAST_PAGE    8'hff
`define MIE_BANK_W       2
`define MIE_ADDR_W       8
`define MIE_BCD_LIMIT    4'h9
`define MIE_BCD_ADJ_LO   8'h06
`define MIE_BCD_ADJ_HI   8'h60
`define MIE_ACC_RST      8'h00
`define MIE_TBL_RST      8'h00
`define MIE_FLAGS_RST    6'h00
`define MIE_SKIP_EXTRA   2'h1

`endif

// *** logic/mie_pkg.sv ***
package mie_pkg;

    typedef enum logic [4:0] {
        MIE_OP_NOP        = 5'h00,
        MIE_OP_SWAP       = 5'h01,
        MIE_OP_NIBBLE_SWAP_TO_ACC      = 5'h02,
        MIE_OP_SKZ        = 5'h03,
        MIE_OP_SKZ_MOVE   = 5'h04,
        MIE_OP_SKZ_BIT    = 5'h05,
        MIE_OP_TBL_PAGED  = 5'h06,
        MIE_OP_TBL_LAST   = 5'h07,
        MIE_OP_ITBL_PAGED = 5'h08,
        MIE_OP_ITBL_LAST  = 5'h09,
        MIE_OP_XOR        = 5'h0a,
        MIE_OP_XOR_IMM    = 5'h0b,
        MIE_OP_XOR_MEM    = 5'h0c,
        MIE_OP_ADC        = 5'h0d,
        MIE_OP_ADD        = 5'h0e,
        MIE_OP_AND        = 5'h0f,
        MIE_OP_CLR        = 5'h10,
        MIE_OP_CLR_BIT    = 5'h11,
        MIE_OP_CPL        = 5'h12,
        MIE_OP_DAA        = 5'h13,
        MIE_OP_DEC        = 5'h14,
        MIE_OP_INC        = 5'h15,
        MIE_OP_MOV        = 5'h16
    } mie_op_e;

    typedef struct packed {
        logic overflow;
        logic zero;
        logic aux_carry;
        logic carry;
        logic signed_carry;
        logic cz;
    } mie_flags_s;

    typedef struct packed {
        mie_op_e    op;
        logic       to_mem;
        logic       long_addr;
        logic [1:0] bank;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] imm;
    } mie_instr_s;

    typedef struct packed {
        logic       write;
        logic [1:0] bank;
        logic [7:0] addr;
        logic [7:0] data;
    } mie_mem_wr_s;

    typedef enum logic [1:0] {
        MIE_ST_IDLE  = 2'h0,
        MIE_ST_EXEC  = 2'h3,
        MIE_ST_DUMMY = 2'h1
    } mie_state_e;

endpackage : mie_pkg

// *** logic/mie_execute.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mie_regs.svh"
// How it works
// RULE_01: Nibble swap to accumulator loads acc with swapped memory nibbles, no flags.
// RULE_02: In-place nibble swap exchanges memory nibbles and affects no flag.
// RULE_03: Skip-if-zero writes memory back unchanged and skips when byte is zero.
// RULE_04: Skip-if-zero-move copies memory to accumulator and skips when zero.
// RULE_05: Bit-test skip skips when the selected memory bit is zero.
// RULE_06: A taken base skip adds one dummy cycle before the next instruction.
// RULE_07: Paged table read uses both pointer bytes; low to memory, high to latch.
// RULE_08: Last-page table read uses pointer low byte on the final page.
// RULE_09: Incrementing paged read bumps pointer low byte, then reads paged.
// RULE_10: Incrementing last-page read bumps pointer low byte, then reads last page.
// RULE_11: XOR to accumulator with memory or immediate, zero flag only.
// RULE_12: XOR to memory stores accumulator XOR memory, zero flag only.
// RULE_13: Extended instructions reach any data memory section, ignoring bank selection.
// RULE_14: Add with carry sums acc, memory, carry; updates OV, Z, AC, C, SC.
// RULE_15: Add sums acc and memory; updates OV, Z, AC, C, SC.
// RULE_16: AND acc with memory to acc or memory, zero flag only.
// RULE_17: Clear zeroes the memory byte or one bit, flags unchanged.
// RULE_18: Complement inverts memory byte to memory or acc, zero flag only.
// RULE_19: Decimal adjust adds 06H and 60H as needed into memory; carry only.
// RULE_20: Decrement memory by one to memory or acc, zero flag only.
// RULE_21: Increment memory by one to memory or acc, zero flag only.
// RULE_22: Move copies memory into accumulator, flags unchanged.
// RULE_23: Extended forms give the same results and flags as base forms.
module mie_execute (
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    input  wire logic                instr_valid_i,
    input  wire mie_pkg::mie_instr_s instr_i,
    input  wire logic [1:0]          bank_select_i,
    input  wire logic [7:0]          mem_rdata_i,
    input  wire logic [15:0]         prog_rdata_i,
    input  wire logic                tbl_ptr_wr_i,
    input  wire logic [7:0]          tbl_ptr_low_wdata_i,
    input  wire logic [7:0]          tbl_ptr_high_wdata_i,
    output logic                     busy_o,
    output logic                     skip_o,
    output logic [15:0]              prog_addr_o,
    output mie_pkg::mie_mem_wr_s     mem_wr_o,
    output logic [7:0]               acc_o,
    output mie_pkg::mie_flags_s      flags_o,
    output logic [7:0]               table_pointer_low_o,
    output logic [7:0]               table_pointer_high_o,
    output logic [7:0]               table_read_high_latch_o
);
    import mie_pkg::*;

    mie_state_e  state_reg;
    mie_state_e  state_next;
    logic [7:0]  acc_reg;
    logic [7:0]  acc_next;
    logic        acc_we;
    mie_flags_s  flags_reg;
    mie_flags_s  flags_next;
    logic [7:0]  tbl_lo_reg;
    logic [7:0]  tbl_hi_reg;
    logic [7:0]  tbl_latch_reg;
    logic        tbl_latch_we;
    mie_mem_wr_s mem_wr_reg;
    mie_mem_wr_s mem_wr_next;
    logic        skip_reg;
    logic        skip_take;
    logic [7:0]  res;
    logic [8:0]  sum9;
    logic [4:0]  sum_lo;
    logic [7:0]  sum7;
    logic [7:0]  daa_lo;
    logic [8:0]  daa9;
    logic [7:0]  tbl_lo_inc;
    logic        is_read_tbl;
    logic        is_inc_tbl;
    logic        carry_in;
    logic [1:0]  eff_bank;

    assign tbl_lo_inc = tbl_lo_reg + 8'h01;
    assign is_inc_tbl = instr_valid_i && state_reg == MIE_ST_IDLE &&
                        (instr_i.op == MIE_OP_ITBL_PAGED || instr_i.op == MIE_OP_ITBL_LAST);
    assign is_read_tbl = instr_i.op == MIE_OP_TBL_PAGED || instr_i.op == MIE_OP_TBL_LAST ||
                         instr_i.op == MIE_OP_ITBL_PAGED || instr_i.op == MIE_OP_ITBL_LAST;

    // RULE_13 bank bypass.
    // Extended forms use their own bank field so the current bank register is ignored.
    assign eff_bank = instr_i.long_addr ? instr_i.bank : bank_select_i;

    // RULE_07 paged address.
    // RULE_08 last page address.
    // RULE_09 incremented pointer.
    // RULE_10 incremented pointer.
    // Combinational, so the word returns in the same cycle.
    always_comb begin
        case (instr_i.op)
            MIE_OP_TBL_PAGED:  prog_addr_o = {tbl_hi_reg, tbl_lo_reg};
            MIE_OP_ITBL_PAGED: prog_addr_o = {tbl_hi_reg, tbl_lo_inc};
            MIE_OP_TBL_LAST:   prog_addr_o = {`MIE_LAST_PAGE, tbl_lo_reg};
            MIE_OP_ITBL_LAST:  prog_addr_o = {`MIE_LAST_PAGE, tbl_lo_inc};
            default:           prog_addr_o = {tbl_hi_reg, tbl_lo_reg};
        endcase
    end

    assign carry_in = (instr_i.op == MIE_OP_ADC) ? flags_reg.carry : 1'b0;
    assign sum9     = {1'b0, acc_reg} + {1'b0, mem_rdata_i} + {8'h00, carry_in};
    assign sum_lo   = {1'b0, acc_reg[3:0]} + {1'b0, mem_rdata_i[3:0]} + {4'h0, carry_in};
    assign sum7     = {1'b0, acc_reg[6:0]} + {1'b0, mem_rdata_i[6:0]} + {7'h00, carry_in};
    assign daa_lo   = (acc_reg[3:0] > `MIE_BCD_LIMIT || flags_reg.aux_carry) ?
                      acc_reg + `MIE_BCD_ADJ_LO : acc_reg;
    assign daa9     = (acc_reg[7:4] > `MIE_BCD_LIMIT || flags_reg.carry) ?
                      {1'b0, daa_lo} + {1'b0, `MIE_BCD_ADJ_HI} : {1'b0, daa_lo};

    always_comb begin
        res         = 8'h00;
        acc_next    = acc_reg;
        acc_we      = 1'b0;
        flags_next  = flags_reg;
        mem_wr_next = '0;
        mem_wr_next.bank = eff_bank;
        mem_wr_next.addr = instr_i.addr;
        skip_take   = 1'b0;
        tbl_latch_we = 1'b0;
        if (instr_valid_i && state_reg == MIE_ST_IDLE) begin
            case (instr_i.op)
                // RULE_02 in-place swap.
                MIE_OP_SWAP: begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
                end
                // RULE_01 swap to accumulator.
                MIE_OP_NIBBLE_SWAP_TO_ACC: begin
                    acc_next = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
                    acc_we   = 1'b1;
                end
                // RULE_03 read, write back.
                MIE_OP_SKZ: begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = mem_rdata_i;
                    skip_take = (mem_rdata_i == 8'h00);
                end
                // RULE_04 copy and test.
                MIE_OP_SKZ_MOVE: begin
                    acc_next  = mem_rdata_i;
                    acc_we    = 1'b1;
                    skip_take = (mem_rdata_i == 8'h00);
                end
                // RULE_05 bit test.
                MIE_OP_SKZ_BIT: begin
                    skip_take = ~mem_rdata_i[instr_i.bit_sel];
                end
                // RULE_07 low byte to memory.
                // RULE_08 same delivery, last page.
                // RULE_09 same delivery after increment.
                // RULE_10 same delivery after increment.
                MIE_OP_TBL_PAGED, MIE_OP_TBL_LAST, MIE_OP_ITBL_PAGED, MIE_OP_ITBL_LAST: begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = prog_rdata_i[7:0];
                    tbl_latch_we      = 1'b1;
                end
                // RULE_11 XOR into accumulator.
                MIE_OP_XOR, MIE_OP_XOR_IMM: begin
                    res = acc_reg ^ ((instr_i.op == MIE_OP_XOR_IMM) ? instr_i.imm : mem_rdata_i);
                    acc_next = res;
                    acc_we   = 1'b1;
                    flags_next.zero = (res == 8'h00);
                end
                // RULE_12 XOR into memory.
                MIE_OP_XOR_MEM: begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = acc_reg ^ mem_rdata_i;
                    flags_next.zero   = ((acc_reg ^ mem_rdata_i) == 8'h00);
                end
                // RULE_14 add with carry.
                // RULE_15 plain add.
                MIE_OP_ADC, MIE_OP_ADD: begin
                    res = sum9[7:0];
                    flags_next.carry        = sum9[8];
                    flags_next.aux_carry    = sum_lo[4];
                    flags_next.overflow     = sum9[8] ^ sum7[7];
                    flags_next.zero         = (res == 8'h00);
                    flags_next.signed_carry = res[7] ^ sum9[8] ^ sum7[7];
                end
                // RULE_16 bitwise AND.
                MIE_OP_AND: begin
                    res = acc_reg & mem_rdata_i;
                    flags_next.zero = (res == 8'h00);
                end
                // RULE_17 clear byte.
                MIE_OP_CLR: begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = 8'h00;
                end
                // RULE_17 clear bit.
                MIE_OP_CLR_BIT: begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = mem_rdata_i & ~(8'h01 << instr_i.bit_sel);
                end
                // RULE_18 complement.
                MIE_OP_CPL: begin
                    res = ~mem_rdata_i;
                    flags_next.zero = (res == 8'h00);
                end
                // RULE_19 decimal adjust.
                // The carry is only ever set here so a multi-byte BCD chain keeps it.
                MIE_OP_DAA: begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = daa9[7:0];
                    if (daa9[8]) begin
                        flags_next.carry = 1'b1;
                    end
                end
                // RULE_20 decrement.
                MIE_OP_DEC: begin
                    res = mem_rdata_i - 8'h01;
                    flags_next.zero = (res == 8'h00);
                end
                // RULE_21 increment.
                MIE_OP_INC: begin
                    res = mem_rdata_i + 8'h01;
                    flags_next.zero = (res == 8'h00);
                end
                // RULE_22 move.
                MIE_OP_MOV: begin
                    acc_next = mem_rdata_i;
                    acc_we   = 1'b1;
                end
                default: begin
                    res = 8'h00;
                end
            endcase
            // RULE_23 shared destination.
            // Base and extended forms pass through the same result steering.
            if (instr_i.op == MIE_OP_ADC || instr_i.op == MIE_OP_ADD ||
                instr_i.op == MIE_OP_AND || instr_i.op == MIE_OP_CPL ||
                instr_i.op == MIE_OP_DEC || instr_i.op == MIE_OP_INC) begin
                if (instr_i.to_mem) begin
                    mem_wr_next.write = 1'b1;
                    mem_wr_next.data  = res;
                end else begin
                    acc_next = res;
                    acc_we   = 1'b1;
                end
            end
        end
    end

    // RULE_06 dummy cycle.
    always_comb begin
        case (state_reg)
            MIE_ST_IDLE:  state_next = skip_take ? MIE_ST_DUMMY : MIE_ST_IDLE;
            MIE_ST_DUMMY: state_next = MIE_ST_IDLE;
            default:      state_next = MIE_ST_IDLE;
        endcase
    end

    // An offer made in the dummy cycle is dropped; busy_o is high for that cycle.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg <= MIE_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // RULE_06 skip pulse.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            skip_reg <= 1'b0;
        end else begin
            skip_reg <= skip_take;
        end
    end

    // RULE_22 accumulator load.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            acc_reg <= `MIE_ACC_RST;
        end else if (acc_we) begin
            acc_reg <= acc_next;
        end
    end

    // Flags reload each cycle; untouched bits hold.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_reg <= `MIE_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // RULE_09 pointer increment.
    // An incrementing read wins over a software pointer load in the same cycle.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tbl_lo_reg <= `MIE_TBL_RST;
        end else if (is_inc_tbl) begin
            tbl_lo_reg <= tbl_lo_inc;
        end else if (tbl_ptr_wr_i) begin
            tbl_lo_reg <= tbl_ptr_low_wdata_i;
        end
    end

    // The high byte never loads alone, keeping the pair coherent.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tbl_hi_reg <= `MIE_TBL_RST;
        end else if (tbl_ptr_wr_i && !is_inc_tbl) begin
            tbl_hi_reg <= tbl_ptr_high_wdata_i;
        end
    end

    // RULE_07 high byte to latch.
    // RULE_08 high byte to latch.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tbl_latch_reg <= `MIE_TBL_RST;
        end else if (tbl_latch_we && is_read_tbl) begin
            tbl_latch_reg <= prog_rdata_i[15:8];
        end
    end

    // Registered, so the write lands one cycle after the read.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mem_wr_reg <= '0;
        end else begin
            mem_wr_reg <= mem_wr_next;
        end
    end

    // RULE_06 busy in dummy.
    assign busy_o                  = (state_reg == MIE_ST_DUMMY);
    assign skip_o                  = skip_reg;
    assign mem_wr_o                = mem_wr_reg;
    assign acc_o                   = acc_reg;
    assign flags_o                 = flags_reg;
    assign table_pointer_low_o     = tbl_lo_reg;
    assign table_pointer_high_o    = tbl_hi_reg;
    assign table_read_high_latch_o = tbl_latch_reg;

endmodule : mie_execute
`default_nettype wire

// *** testbench/mie_execute_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module mie_execute_sva
    import mie_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        instr_valid_i,
    input wire mie_instr_s  instr_i,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic [15:0] prog_rdata_i,
    input wire logic        tbl_ptr_wr_i,
    input wire logic        busy_o,
    input wire logic        skip_o,
    input wire logic [15:0] prog_addr_o,
    input wire mie_mem_wr_s mem_wr_o,
    input wire logic [7:0]  acc_o,
    input wire mie_flags_s  flags_o,
    input wire logic [7:0]  table_pointer_low_o,
    input wire logic [7:0]  table_pointer_high_o,
    input wire logic [7:0]  table_read_high_latch_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic    go;
    logic    bit_zero;
    mie_op_e op;
    assign go = instr_valid_i && !busy_o;
    assign op = instr_i.op;
    assign bit_zero = !mem_rdata_i[instr_i.bit_sel];
    sequence dummy_s;
        skip_o && busy_o ##1 !busy_o;
    endsequence
    chk_skz_dummy: assert property (
        go && op == MIE_OP_SKZ && mem_rdata_i == 8'h00 |=> dummy_s)
        else $error("zero skip lacks one dummy cycle");
    chk_skz_wback: assert property (
        go && op == MIE_OP_SKZ |=> mem_wr_o.write && mem_wr_o.data == $past(mem_rdata_i))
        else $error("skip test did not write the byte back");
    chk_sza_move: assert property (
        go && op == MIE_OP_SKZ_MOVE |=> acc_o == $past(mem_rdata_i)
        && skip_o == (acc_o == 8'h00) && $stable(flags_o))
        else $error("skip with move gave wrong result");
    chk_bit_skip: assert property (
        go && op == MIE_OP_SKZ_BIT |=> skip_o == $past(bit_zero))
        else $error("bit test skip wrong");
    chk_swap_acc: assert property (
        go && op == MIE_OP_NIBBLE_SWAP_TO_ACC |=> $stable(flags_o)
        && acc_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
        else $error("nibble swap to accumulator wrong");
    chk_tbl_paged: assert property (
        go && op == MIE_OP_TBL_PAGED |-> prog_addr_o == {table_pointer_high_o, table_pointer_low_o}
        ##1 mem_wr_o.data == $past(prog_rdata_i[7:0])
        && table_read_high_latch_o == $past(prog_rdata_i[15:8]))
        else $error("paged table read wrong");
    chk_itbl_last: assert property (
        go && op == MIE_OP_ITBL_LAST && !tbl_ptr_wr_i
        |-> prog_addr_o == {8'hff, table_pointer_low_o + 8'h01}
        ##1 table_pointer_low_o == $past(table_pointer_low_o) + 8'h01)
        else $error("incrementing last page read wrong");
    chk_xor_mem: assert property (
        go && op == MIE_OP_XOR_MEM |=> mem_wr_o.data == ($past(acc_o) ^ $past(mem_rdata_i))
        && flags_o.zero == (mem_wr_o.data == 8'h00))
        else $error("exclusive or to memory wrong");
    chk_clr_mem: assert property (
        go && op == MIE_OP_CLR |=> mem_wr_o.write && mem_wr_o.data == 8'h00 && $stable(flags_o))
        else $error("clear did not zero the byte");
endmodule : mie_execute_sva
`default_nettype wire

// *** testbench/mie_memory_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module mie_memory_model
    import mie_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire mie_instr_s  instr_i,
    input  wire logic [1:0]  bank_select_i,
    input  wire logic [15:0] prog_addr_i,
    input  wire mie_mem_wr_s mem_wr_i,
    output logic [7:0]       mem_rdata_o,
    output logic [15:0]      prog_rdata_o
);
    logic [7:0] mem [0:1023];
    logic [1:0] bank;
    assign bank = instr_i.long_addr ? instr_i.bank : bank_select_i;
    assign mem_rdata_o = mem[{bank, instr_i.addr}];
    // Each word mixes its own address, so a wrong page or offset shows up.
    assign prog_rdata_o = {~prog_addr_i[7:0], prog_addr_i[15:8] ^ prog_addr_i[7:0]};
    always @(posedge mclk_i) begin
        if (mem_wr_i.write) begin
            mem[{mem_wr_i.bank, mem_wr_i.addr}] <= mem_wr_i.data;
        end
    end
endmodule : mie_memory_model
`default_nettype wire

// *** testbench/mie_execute_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module mie_execute_bench;
    import mie_pkg::*;
    logic        mclk_i;
    logic        rst_i;
    logic        instr_valid_i;
    mie_instr_s  instr_i;
    logic [1:0]  bank_select_i;
    logic [7:0]  mem_rdata_i;
    logic [15:0] prog_rdata_i;
    logic        tbl_ptr_wr_i;
    logic        busy_o;
    logic        skip_o;
    logic [15:0] prog_addr_o;
    mie_mem_wr_s mem_wr_o;
    logic [7:0]  acc_o;
    mie_flags_s  flags_o;
    logic [7:0]  table_pointer_low_o;
    logic [7:0]  table_pointer_high_o;
    logic [7:0]  table_read_high_latch_o;
    int          failures;
    int          checked;
    int          cycles;
    mie_execute mie_execute_inst (.mclk_i, .rst_i, .instr_valid_i, .instr_i, .bank_select_i,
        .mem_rdata_i, .prog_rdata_i, .tbl_ptr_wr_i, .tbl_ptr_low_wdata_i(8'hfe),
        .tbl_ptr_high_wdata_i(8'h22), .busy_o, .skip_o, .prog_addr_o, .mem_wr_o, .acc_o,
        .flags_o, .table_pointer_low_o, .table_pointer_high_o, .table_read_high_latch_o);
    mie_memory_model mie_memory_model_inst (.mclk_i, .instr_i, .bank_select_i,
        .prog_addr_i(prog_addr_o), .mem_wr_i(mem_wr_o), .mem_rdata_o(mem_rdata_i),
        .prog_rdata_o(prog_rdata_i));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // The wrong bank always holds the inverse, so a bank slip cannot pass.
    task automatic run(input mie_op_e op, input logic [7:0] mv, input logic tm, input logic lg);
        mie_memory_model_inst.mem[{2'h1, 8'h40}] = lg ? ~mv : mv;
        mie_memory_model_inst.mem[{2'h2, 8'h40}] = lg ? mv : ~mv;
        instr_i = '{op, tm, lg, 2'h2, 8'h40, 3'h5, 8'h5a};
        instr_valid_i = 1'b1;
        @(posedge mclk_i);
        #1;
    endtask : run
    task automatic idle();
        instr_valid_i = 1'b0;
        @(posedge mclk_i);
        #1;
    endtask : idle
    function automatic logic [8:0] ref_op(mie_op_e op, logic [7:0] a, logic [7:0] m, logic c);
        case (op)
            MIE_OP_XOR, MIE_OP_XOR_MEM: return {1'b0, a ^ m};
            MIE_OP_XOR_IMM: return {1'b0, a ^ 8'h5a};
            MIE_OP_ADD: return a + m;
            MIE_OP_ADC: return a + m + c;
            MIE_OP_AND: return {1'b0, a & m};
            MIE_OP_CPL: return {1'b0, ~m};
            MIE_OP_DEC: return {1'b0, m - 8'h01};
            MIE_OP_INC: return {1'b0, m + 8'h01};
            MIE_OP_CLR: return 9'h000;
            MIE_OP_CLR_BIT: return {1'b0, m & 8'hdf};
            default: return {1'b0, m};
        endcase
    endfunction : ref_op
    task automatic t_alu();
        mie_op_e    ops [13];
        mie_op_e    op;
        logic [7:0] mv;
        logic [7:0] ea;
        logic       ec;
        logic [8:0] r;
        logic [8:0] sx;
        logic [4:0] nib;
        mie_flags_s f0;
        ops = '{MIE_OP_XOR, MIE_OP_XOR_IMM, MIE_OP_XOR_MEM, MIE_OP_ADD, MIE_OP_ADC, MIE_OP_AND,
            MIE_OP_CPL, MIE_OP_DEC, MIE_OP_INC, MIE_OP_MOV, MIE_OP_CLR, MIE_OP_CLR_BIT, MIE_OP_ADC};
        ea = 8'h00;
        ec = 1'b0;
        for (int k = 0; k < 39; k++) begin
            op = ops[k % 13];
            mv = (k % 3 == 0) ? ea : ((k % 3 == 1) ? 8'h01 : 8'hff);
            f0 = flags_o;
            r = ref_op(op, ea, mv, ec);
            sx = {ea[7], ea} + {mv[7], mv} + {8'h00, ec && op == MIE_OP_ADC};
            nib = {1'b0, ea[3:0]} + {1'b0, mv[3:0]} + {4'h0, ec && op == MIE_OP_ADC};
            run(op, mv, k[0], k >= 13);
            if (op inside {MIE_OP_ADD, MIE_OP_ADC}) begin
                cmp("add flags", {13'h0, sx[8] ^ sx[7], nib[4], sx[8]},
                    {13'h0, flags_o.overflow, flags_o.aux_carry, flags_o.signed_carry});
            end
            if (op inside {MIE_OP_XOR_MEM, MIE_OP_CLR, MIE_OP_CLR_BIT} || (k[0] && op inside
                {MIE_OP_ADD, MIE_OP_ADC, MIE_OP_AND, MIE_OP_CPL, MIE_OP_DEC, MIE_OP_INC})) begin
                cmp("memory result", {5'h00, k >= 13, k < 13, 1'b1, r[7:0]}, {5'h00,
                    mem_wr_o.bank, mem_wr_o.write, mem_wr_o.data});
            end else begin
                cmp("acc result", {8'h00, r[7:0]}, {8'h00, acc_o});
                ea = r[7:0];
            end
            if (op inside {MIE_OP_MOV, MIE_OP_CLR, MIE_OP_CLR_BIT}) begin
                cmp("flags", {10'h000, f0}, {10'h000, flags_o});
            end else begin
                cmp("zero", {15'h0000, r[7:0] == 8'h00}, {15'h0000, flags_o.zero});
            end
            ec = (op inside {MIE_OP_ADD, MIE_OP_ADC}) ? r[8] : ec;
            cmp("carry", {15'h0000, ec}, {15'h0000, flags_o.carry});
        end
    endtask : t_alu
    task automatic t_daa();
        logic [31:0] rows [2];
        rows = '{32'h38458300, 32'h99999801};
        foreach (rows[i]) begin
            run(MIE_OP_MOV, rows[i][31:24], 1'b0, 1'b1);
            run(MIE_OP_ADD, rows[i][23:16], 1'b0, 1'b1);
            run(MIE_OP_DAA, 8'h00, 1'b1, 1'b1);
            cmp("adjusted", {7'h00, rows[i][0], rows[i][15:8]},
                {7'h00, flags_o.carry, mem_wr_o.data});
        end
    endtask : t_daa
    task automatic t_swap_skip();
        run(MIE_OP_NIBBLE_SWAP_TO_ACC, 8'h3c, 1'b0, 1'b0);
        cmp("swapped acc", 16'h00c3, {8'h00, acc_o});
        run(MIE_OP_SWAP, 8'h71, 1'b0, 1'b0);
        cmp("swapped byte", 16'hc317, {acc_o, mem_wr_o.data});
        run(MIE_OP_SKZ, 8'h00, 1'b0, 1'b0);
        cmp("zero skip", 16'h0300, {6'h00, busy_o, skip_o, mem_wr_o.data});
        run(MIE_OP_MOV, 8'h66, 1'b0, 1'b0);
        cmp("refused", 16'h00c3, {6'h00, busy_o, skip_o, acc_o});
        run(MIE_OP_SKZ, 8'h80, 1'b0, 1'b0);
        cmp("no skip", 16'h0000, {14'h0000, busy_o, skip_o});
        run(MIE_OP_SKZ_MOVE, 8'h00, 1'b0, 1'b0);
        cmp("move skip", 16'h0300, {6'h00, busy_o, skip_o, acc_o});
        idle();
        run(MIE_OP_SKZ_MOVE, 8'h09, 1'b0, 1'b0);
        cmp("move stay", 16'h0009, {6'h00, busy_o, skip_o, acc_o});
        run(MIE_OP_SKZ_BIT, 8'hdf, 1'b0, 1'b0);
        cmp("bit skip", 16'h0003, {14'h0000, busy_o, skip_o});
        idle();
        run(MIE_OP_SKZ_BIT, 8'h20, 1'b0, 1'b0);
        cmp("bit stay", 16'h0000, {14'h0000, busy_o, skip_o});
    endtask : t_swap_skip
    task automatic t_table();
        mie_op_e     tops [4];
        logic [7:0]  lo;
        logic [15:0] w;
        tops = '{MIE_OP_TBL_PAGED, MIE_OP_TBL_LAST, MIE_OP_ITBL_PAGED, MIE_OP_ITBL_LAST};
        idle();
        tbl_ptr_wr_i = 1'b1;
        idle();
        tbl_ptr_wr_i = 1'b0;
        cmp("pointer high", 16'h0022, {8'h00, table_pointer_high_o});
        lo = 8'hfe;
        for (int k = 0; k < 4; k++) begin
            lo = lo + ((k >= 2) ? 8'h01 : 8'h00);
            w = {~lo, (k[0] ? 8'hff : 8'h22) ^ lo};
            run(tops[k], 8'h00, 1'b0, 1'b0);
            cmp("table low", {8'h01, w[7:0]}, {7'h00, mem_wr_o.write, mem_wr_o.data});
            cmp("table high", {lo, w[15:8]}, {table_pointer_low_o, table_read_high_latch_o});
        end
    endtask : t_table
    initial begin
        failures = 0;
        checked = 0;
        cycles = 0;
        rst_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = '0;
        bank_select_i = 2'h1;
        tbl_ptr_wr_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        cmp("reset", 16'h0000, {acc_o, 2'b00, flags_o});
        t_alu();
        t_daa();
        t_swap_skip();
        t_table();
        idle();
        tally_and_finish();
    end
endmodule : mie_execute_bench
bind mie_execute mie_execute_sva mie_execute_sva_inst (.mclk_i, .rst_i, .instr_valid_i,
    .instr_i, .mem_rdata_i, .prog_rdata_i, .tbl_ptr_wr_i, .busy_o, .skip_o, .prog_addr_o,
    .mem_wr_o, .acc_o, .flags_o, .table_pointer_low_o, .table_pointer_high_o,
    .table_read_high_latch_o);
`default_nettype wire
